/* ict_timing.sv */
module ict_timing
	import ict_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Request side
	input wire logic req_valid,
	input wire ict_pkg::ict_req_t req,
	output logic req_ready,
	// Answer side
	output logic rsp_valid,
	output ict_pkg::ict_rsp_t rsp,
	// Instruction in progress
	output logic busy
);
	import ict_pkg::*;

	// How a request moves through the block:
	// Idle: ready is high, a valid request is copied into req_ff.
	// Eval: the held copy is weighed against the table walk in one cycle.
	// Run: busy stands for exactly the reported number of clocks.
	// A refused request goes from eval straight back to idle with
	// an answer that carries no cost, so it never occupies the bus.
	// The copy in req_ff keeps the table walk away from the live
	// request pins, which may change as soon as the request is taken.
	// Trade-off: one extra cycle of latency buys a short, registered
	// path from the request pins into the table walk.
	// Limitation: only one request is in flight at any time; the
	// requester has to wait for ready before it offers the next one.

	// Controller state
	ict_state_t state_ff;
	ict_state_t nxt_state;

	// Request held for the whole instruction
	ict_req_t req_ff;

	// Clocks still to spend in the run phase
	logic [TOTAL_CLK_W-1:0] cnt_ff;
	logic [TOTAL_CLK_W-1:0] nxt_cnt;

	// Output flops
	logic ready_ff;
	logic rsp_valid_ff;
	logic busy_ff;
	ict_rsp_t rsp_ff;
	ict_rsp_t nxt_rsp;

	// Entries from the table walk
	ict_cost_t base_cost;
	ict_cost_t loop_cost;
	logic base_plus;
	logic base_ok;
	logic loop_ok;

	// Table walk on the held request
	ict_cost_lookup u_lookup (
		.op_i(req_ff.op),
		.size_i(req_ff.size),
		.form_i(req_ff.form),
		.base_o(base_cost),
		.plus_o(base_plus),
		.base_ok_o(base_ok),
		.loop_o(loop_cost),
		.loop_ok_o(loop_ok)
	);

	// Request handshake
	wire take = req_valid && ready_ff;

	// Phase decode
	wire in_idle = (state_ff == ST_IDLE);
	wire in_eval = (state_ff == ST_EVAL);
	wire in_run = (state_ff == ST_RUN);

	// Field decode of the held request
	wire size_ok = (req_ff.size != 2'h3);
	wire is_byte = (req_ff.size == SZ_BYTE);
	wire to_areg = (req_ff.form == FORM_TO_AREG);
	wire to_dreg = (req_ff.form == FORM_TO_DREG);
	wire is_xor = (req_ff.op == OP_EXCLUSIVE_OR);

	// Divide and multiply have a single fixed size
	wire is_muldiv = (req_ff.op == OP_SIGNED_DIVISION) ||
		(req_ff.op == OP_UNSIGNED_DIVISION) ||
		(req_ff.op == OP_SIGNED_MULTIPLICATION) ||
		(req_ff.op == OP_UNSIGNED_MULTIPLICATION);
	wire muldiv_ok = !is_muldiv || (req_ff.size == SZ_WORD);

	// No byte-sized form writes an address register
	wire areg_size_ok = !(to_areg && is_byte);

	// Register exclusive-or has only the data register source
	wire xor_src_ok = !(is_xor && to_dreg) || req_ff.src_is_dreg;

	// Loop mode is limited to three addressing modes
	wire mode_in_loop_set = (req_ff.eff_mode != AM_OTHER);
	wire loop_req_ok = !req_ff.loop_en || (loop_ok && mode_in_loop_set);

	// Loop state code 3 is never valid in loop mode
	wire loop_state_ok = !req_ff.loop_en || (req_ff.loop_state != 2'h3);

	// Overall acceptance of the held request
	wire legal = base_ok && size_ok && muldiv_ok && areg_size_ok &&
		xor_src_ok && loop_req_ok && loop_state_ok;

	// Address cost joins only entries that ask for it
	wire add_eff = base_plus && !req_ff.loop_en;
	wire [7:0] eff_clk = add_eff ? req_ff.eff_cost.clk : 8'h00;
	wire [3:0] eff_rd = add_eff ? req_ff.eff_cost.rd : 4'h0;
	wire [3:0] eff_wr = add_eff ? req_ff.eff_cost.wr : 4'h0;

	// Plain total: entry plus address cost
	wire [TOTAL_CLK_W-1:0] plain_clk = {2'b00, base_cost.clk} + {2'b00, eff_clk};
	wire [TOTAL_CYC_W-1:0] plain_rd = {1'b0, base_cost.rd} + {1'b0, eff_rd};
	wire [TOTAL_CYC_W-1:0] plain_wr = {1'b0, base_cost.wr} + {1'b0, eff_wr};

	// Loop exit surcharge chosen by the loop outcome
	wire loop_true = (req_ff.loop_state == LOOP_TRUE);
	wire loop_exp = (req_ff.loop_state == LOOP_EXPIRED);
	wire [7:0] exit_clk = loop_true ? LOOP_TRUE_EXTRA.clk :
		(loop_exp ? LOOP_EXPIRED_EXTRA.clk : 8'h00);
	wire [3:0] exit_rd = loop_true ? LOOP_TRUE_EXTRA.rd :
		(loop_exp ? LOOP_EXPIRED_EXTRA.rd : 4'h0);

	// Predecrement costs extra in the loop
	wire predec = (req_ff.eff_mode == AM_PREDEC);
	wire [7:0] predec_clk = predec ? PREDEC_EXTRA_CLK : 8'h00;

	// Loop total: entry, exit surcharge and predecrement surcharge
	wire [TOTAL_CLK_W-1:0] loop_clk = {2'b00, loop_cost.clk} +
		{2'b00, exit_clk} + {2'b00, predec_clk};
	wire [TOTAL_CYC_W-1:0] loop_rd = {1'b0, loop_cost.rd} + {1'b0, exit_rd};
	wire [TOTAL_CYC_W-1:0] loop_wr = {1'b0, loop_cost.wr};

	// Final figures for the answer
	wire [TOTAL_CLK_W-1:0] sel_clk = req_ff.loop_en ? loop_clk : plain_clk;
	wire [TOTAL_CYC_W-1:0] sel_rd = req_ff.loop_en ? loop_rd : plain_rd;
	wire [TOTAL_CYC_W-1:0] sel_wr = req_ff.loop_en ? loop_wr : plain_wr;

	// Last run cycle; a zero count is treated as done so the run never hangs
	wire run_last = (cnt_ff <= {{(TOTAL_CLK_W-1){1'b0}}, 1'b1});

	// Answer is produced after a refused request or the last run cycle
	wire finish_illegal = in_eval && !legal;
	wire finish_run = in_run && run_last;

	// Sequencing notes:
	// The run phase lasts as many cycles as the total clock count,
	// so busy models the real bus occupancy of the instruction.
	// The answer word is written in the eval cycle and then stands
	// until the next request is weighed; the valid pulse only marks
	// the cycle in which the run has ended or the request was refused.
	// A total of zero cannot come out of the tables, but the done
	// test treats it as the last run cycle so the block cannot hang.
	// The default branch only guards against a broken one-hot code.

	// Next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_EVAL;
				end
			end
			ST_EVAL: begin
				// Refused requests skip the run phase
				nxt_state = legal ? ST_RUN : ST_IDLE;
			end
			ST_RUN: begin
				if (run_last) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				// Any broken code falls back to idle
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Count loads the whole total so the run spans every counted clock
	always_comb begin
		nxt_cnt = cnt_ff;
		if (in_eval) begin
			nxt_cnt = legal ? sel_clk : '0;
		end else if (in_run && !run_last) begin
			nxt_cnt = cnt_ff - {{(TOTAL_CLK_W-1){1'b0}}, 1'b1};
		end
	end

	// Answer word, captured once the request has been weighed
	always_comb begin
		nxt_rsp = rsp_ff;
		if (in_eval) begin
			nxt_rsp.illegal = !legal;
			nxt_rsp.clk = legal ? sel_clk : '0;
			nxt_rsp.rd = legal ? sel_rd : '0;
			nxt_rsp.wr = legal ? sel_wr : '0;
		end
	end

	// Controller registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// Request capture; only a taken request overwrites the copy
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ff <= '0;
		end else if (take) begin
			req_ff <= req;
		end
	end

	// Register notes:
	// Every output is taken straight from a flop so a requester on
	// the same clock sees clean, settled levels at each edge.
	// Reset values: ready high, valid low, busy low, answer zero.
	// Ready and busy are computed from the next state so they change
	// on the same edge as the state itself, without a cycle of lag.
	// The answer flops load only in eval; at all other times the
	// next-value logic returns the current word, so it holds steady.
	// The valid flop is a one-cycle pulse: it rises on the edge that
	// ends the run or refuses the request and falls on the next one.
	// Because ready rises on that same edge, a new request can be
	// taken back to back with the answer of the previous one.

	// Answer registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_ff <= '0;
			rsp_valid_ff <= 1'b0;
		end else begin
			rsp_ff <= nxt_rsp;
			rsp_valid_ff <= finish_illegal || finish_run;
		end
	end

	// Ready and busy follow the next state so they come from flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_ff <= 1'b1;
			busy_ff <= 1'b0;
		end else begin
			ready_ff <= (nxt_state == ST_IDLE);
			busy_ff <= (nxt_state == ST_RUN);
		end
	end

	// Port drivers
	// Plain wires from the flops above; no logic sits between the
	// registers and the pins, so output timing is a flop delay only.
	// Limitation: the answer reflects the maximum figure for divide
	// and multiply; data-dependent timing is not modelled here.
	// Loop exit surcharges are shared by all loop-capable operations.
	assign req_ready = ready_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp = rsp_ff;
	assign busy = busy_ff;

	// Idle decode kept for clarity of the handshake timing
	wire unused_idle = in_idle;

endmodule : ict_timing

/* ict_pkg.sv */
package ict_pkg;

	// Operation selector; codes above the last one are refused
	typedef enum logic [4:0] {
		OP_ADD, OP_AND, OP_CMP, OP_EXCLUSIVE_OR, OP_OR, OP_SUB,
		OP_SIGNED_DIVISION, OP_UNSIGNED_DIVISION,
		OP_SIGNED_MULTIPLICATION, OP_UNSIGNED_MULTIPLICATION,
		OP_ADD_IMMEDIATE, OP_AND_IMM, OP_COMPARE_IMMEDIATE, OP_XOR_IMM,
		OP_OR_IMM, OP_SUB_IMM, OP_ADD_QUICK, OP_SUB_QUICK,
		OP_QUICK_CONSTANT_LOAD
	} ict_op_t;

	// Operand size; code 3 is refused
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} ict_size_t;

	// Destination form: address register, data register or memory
	typedef enum logic [1:0] {FORM_TO_AREG, FORM_TO_DREG, FORM_TO_MEM} ict_form_t;

	// Addressing mode of the memory operand
	typedef enum logic [1:0] {AM_REG_IND, AM_POSTINC, AM_PREDEC, AM_OTHER} ict_mode_t;

	// Loop outcome while in loop mode
	typedef enum logic [1:0] {LOOP_CONT, LOOP_TRUE, LOOP_EXPIRED} ict_loop_t;

	// Controller states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EVAL = 3'h2,
		ST_RUN = 3'h4
	} ict_state_t;

	// Widths of the answer fields
	localparam int TOTAL_CLK_W = 10;
	localparam int TOTAL_CYC_W = 5;

	// One timing entry: clocks, read cycles, write cycles
	typedef struct packed {
		logic [7:0] clk;
		logic [3:0] rd;
		logic [3:0] wr;
	} ict_cost_t;

	// One request
	typedef struct packed {
		ict_op_t op;
		ict_size_t size;
		ict_form_t form;
		logic src_is_dreg;
		ict_mode_t eff_mode;
		ict_cost_t eff_cost;
		logic loop_en;
		ict_loop_t loop_state;
	} ict_req_t;

	// One answer
	typedef struct packed {
		logic illegal;
		logic [TOTAL_CLK_W-1:0] clk;
		logic [TOTAL_CYC_W-1:0] rd;
		logic [TOTAL_CYC_W-1:0] wr;
	} ict_rsp_t;

	// Plain table entries
	localparam ict_cost_t T_DREG_BW = '{8'h04, 4'h1, 4'h0};
	localparam ict_cost_t T_DREG_L = '{8'h06, 4'h1, 4'h0};
	localparam ict_cost_t T_AREG_BW = '{8'h08, 4'h1, 4'h0};
	localparam ict_cost_t T_MEM_BW = '{8'h08, 4'h1, 4'h1};
	localparam ict_cost_t T_MEM_L = '{8'h0C, 4'h1, 4'h2};
	localparam ict_cost_t T_SDIV = '{8'h7A, 4'h1, 4'h0};
	localparam ict_cost_t T_UDIV = '{8'h6C, 4'h1, 4'h0};
	localparam ict_cost_t T_MUL = '{8'h2A, 4'h1, 4'h0};
	localparam ict_cost_t T_IMM_BW = '{8'h08, 4'h2, 4'h0};
	localparam ict_cost_t T_IMM_L = '{8'h0E, 4'h3, 4'h0};
	localparam ict_cost_t T_IMM_MEM_BW = '{8'h0C, 4'h2, 4'h1};
	localparam ict_cost_t T_IMM_MEM_L = '{8'h14, 4'h3, 4'h2};
	localparam ict_cost_t T_ANDI_MEM_L = '{8'h14, 4'h3, 4'h1};
	localparam ict_cost_t T_COMPARE_IMMEDIATE_OP_L = '{8'h0C, 4'h3, 4'h0};
	localparam ict_cost_t T_QUICK_AREG_L = '{8'h08, 4'h1, 4'h1};
	localparam ict_cost_t T_QUICK_MEM_BW = '{8'h08, 4'h1, 4'h2};

	// Loop-continued entries
	localparam ict_cost_t L_AREG_BW = '{8'h12, 4'h1, 4'h0};
	localparam ict_cost_t L_REG_L = '{8'h16, 4'h2, 4'h0};
	localparam ict_cost_t L_REG_BW = '{8'h10, 4'h1, 4'h0};
	localparam ict_cost_t L_MEM_BW = '{8'h10, 4'h1, 4'h1};
	localparam ict_cost_t L_MEM_L = '{8'h18, 4'h2, 4'h2};
	localparam ict_cost_t L_CMP_BW = '{8'h0C, 4'h1, 4'h0};
	localparam ict_cost_t L_CMP_L = '{8'h12, 4'h2, 4'h0};
	localparam ict_cost_t L_SUB_DREG_L = '{8'h14, 4'h2, 4'h0};

	// Loop exit surcharges and the predecrement surcharge
	localparam ict_cost_t LOOP_TRUE_EXTRA = '{8'h06, 4'h2, 4'h0};
	localparam ict_cost_t LOOP_EXPIRED_EXTRA = '{8'h04, 4'h2, 4'h0};
	localparam logic [7:0] PREDEC_EXTRA_CLK = 8'h02;

endpackage : ict_pkg

/* ict_cost_lookup.sv */
module ict_cost_lookup
	import ict_pkg::*;
(
	// Request fields
	input wire ict_pkg::ict_op_t op_i,
	input wire ict_pkg::ict_size_t size_i,
	input wire ict_pkg::ict_form_t form_i,
	// Plain entry
	output ict_pkg::ict_cost_t base_o,
	output logic plus_o,
	output logic base_ok_o,
	// Loop-continued entry
	output ict_pkg::ict_cost_t loop_o,
	output logic loop_ok_o
);
	import ict_pkg::*;

	// Byte and word share one column
	wire bw = (size_i != SZ_LONG);
	wire to_a = (form_i == FORM_TO_AREG);
	wire to_d = (form_i == FORM_TO_DREG);

	// Table walk: one entry per operation, size and form
	always_comb begin
		base_o = '0;
		plus_o = 1'b1;
		base_ok_o = 1'b0;
		loop_o = '0;
		loop_ok_o = 1'b0;
		unique case (op_i)
			OP_ADD, OP_SUB: begin
				base_ok_o = 1'b1;
				loop_ok_o = 1'b1;
				if (to_a) begin
					base_o = bw ? T_AREG_BW : T_DREG_L;
					loop_o = bw ? L_AREG_BW : L_REG_L;
				end else if (to_d) begin
					base_o = bw ? T_DREG_BW : T_DREG_L;
					loop_o = bw ? L_REG_BW : ((op_i == OP_SUB) ? L_SUB_DREG_L : L_REG_L);
				end else begin
					base_o = bw ? T_MEM_BW : T_MEM_L;
					loop_o = bw ? L_MEM_BW : L_MEM_L;
				end
			end
			OP_AND, OP_OR: begin
				base_ok_o = !to_a;
				loop_ok_o = !to_a;
				base_o = to_d ? (bw ? T_DREG_BW : T_DREG_L) : (bw ? T_MEM_BW : T_MEM_L);
				// The byte and word memory form of OR reads but shows no write in the loop
				if (to_d || op_i == OP_OR) begin
					loop_o = bw ? L_REG_BW : (to_d ? L_REG_L : L_MEM_L);
				end else begin
					loop_o = bw ? L_MEM_BW : L_MEM_L;
				end
			end
			OP_CMP: begin
				base_ok_o = (form_i != FORM_TO_MEM);
				loop_ok_o = base_ok_o;
				base_o = (bw && to_d) ? T_DREG_BW : T_DREG_L;
				loop_o = bw ? L_CMP_BW : L_CMP_L;
			end
			OP_EXCLUSIVE_OR: begin
				base_ok_o = !to_a;
				// Register form takes no address cost and has no loop form
				plus_o = !to_d;
				loop_ok_o = (form_i == FORM_TO_MEM);
				base_o = to_d ? (bw ? T_DREG_BW : T_DREG_L) : (bw ? T_MEM_BW : T_MEM_L);
				loop_o = bw ? L_REG_BW : L_MEM_L;
			end
			OP_SIGNED_DIVISION: begin
				base_ok_o = to_d;
				base_o = T_SDIV;
			end
			OP_UNSIGNED_DIVISION: begin
				base_ok_o = to_d;
				base_o = T_UDIV;
			end
			OP_SIGNED_MULTIPLICATION, OP_UNSIGNED_MULTIPLICATION: begin
				base_ok_o = to_d;
				base_o = T_MUL;
			end
			OP_ADD_IMMEDIATE, OP_XOR_IMM, OP_OR_IMM, OP_SUB_IMM, OP_AND_IMM: begin
				base_ok_o = !to_a;
				plus_o = !to_d;
				if (to_d) begin
					base_o = bw ? T_IMM_BW : T_IMM_L;
				end else if (!bw && op_i == OP_AND_IMM) begin
					base_o = T_ANDI_MEM_L;
				end else begin
					base_o = bw ? T_IMM_MEM_BW : T_IMM_MEM_L;
				end
			end
			OP_COMPARE_IMMEDIATE: begin
				base_ok_o = !to_a;
				plus_o = !to_d;
				base_o = bw ? T_IMM_BW : T_COMPARE_IMMEDIATE_OP_L;
			end
			OP_ADD_QUICK, OP_SUB_QUICK: begin
				base_ok_o = 1'b1;
				plus_o = (form_i == FORM_TO_MEM);
				if (bw) begin
					base_o = to_d || to_a ? T_DREG_BW :
						((op_i == OP_ADD_QUICK) ? T_QUICK_MEM_BW : T_MEM_BW);
				end else begin
					base_o = to_d ? T_AREG_BW : (to_a ? ((op_i == OP_ADD_QUICK) ? T_QUICK_AREG_L : T_AREG_BW) : T_MEM_L);
				end
			end
			OP_QUICK_CONSTANT_LOAD: begin
				base_ok_o = to_d && !bw;
				plus_o = 1'b0;
				base_o = T_DREG_BW;
			end
			default: begin
				base_ok_o = 1'b0;
			end
		endcase
	end

endmodule : ict_cost_lookup

/* ict_timing_sva.sv */
module ict_timing_sva
	import ict_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Request side
	input wire logic req_valid,
	input wire ict_pkg::ict_req_t req,
	input wire logic req_ready,
	// Answer side
	input wire logic rsp_valid,
	input wire ict_pkg::ict_rsp_t rsp,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Request taken at this edge
	wire take = req_valid && req_ready;
	// Data register destination with loop mode off
	wire plain = take && !req.loop_en && req.form == FORM_TO_DREG;
	// Busy cycles since the last take; a counter, since repetition cannot reach 122
	logic [9:0] bcnt_ff;
	logic [9:0] nxt_bcnt;
	assign nxt_bcnt = take ? 10'h000 : (busy ? bcnt_ff + 10'h001 : bcnt_ff);
	// Counter register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt_ff <= 10'h000;
		end else begin
			bcnt_ff <= nxt_bcnt;
		end
	end
	AST_READY_DROPS: assert property (take |=> !req_ready)
		else $error("ready stayed high after a take");
	AST_ANSWER_TIME: assert property (take |-> ##2 (rsp.illegal ? rsp_valid : busy))
		else $error("answer or run not started two edges after take");
	AST_BUSY_LENGTH: assert property (rsp_valid && !rsp.illegal |-> bcnt_ff == rsp.clk)
		else $error("run length differs from reported clocks");
	AST_REFUSED_CLEAN: assert property (rsp.illegal |-> !busy && rsp.clk == 10'h000 && rsp.rd == 5'h00)
		else $error("refused answer carries a cost");
	AST_BYTE_AREG: assert property (take && req.size == SZ_BYTE && req.form == FORM_TO_AREG |-> ##2 rsp.illegal)
		else $error("byte to address register accepted");
	AST_SDIV: assert property (plain && req.size == SZ_WORD && req.op == OP_SIGNED_DIVISION
		|-> ##2 rsp.clk == 10'h07A + $past(req.eff_cost.clk, 2))
		else $error("signed divide clocks wrong");
	AST_UDIV: assert property (plain && req.size == SZ_WORD && req.op == OP_UNSIGNED_DIVISION
		|-> ##2 rsp.clk == 10'h06C + $past(req.eff_cost.clk, 2))
		else $error("unsigned divide clocks wrong");
	AST_MUL: assert property (plain && req.size == SZ_WORD
		&& req.op inside {OP_SIGNED_MULTIPLICATION, OP_UNSIGNED_MULTIPLICATION}
		|-> ##2 rsp.clk == 10'h02A + $past(req.eff_cost.clk, 2) && rsp.rd == 5'h01 + $past(req.eff_cost.rd, 2))
		else $error("multiply cost wrong");
	AST_ADD_IMM: assert property (plain && req.size inside {SZ_BYTE, SZ_WORD} && req.op == OP_ADD_IMMEDIATE
		|-> ##2 rsp.clk == 10'h008 && rsp.rd == 5'h02 && rsp.wr == 5'h00)
		else $error("add immediate cost wrong");
	AST_QUICK: assert property (plain && req.op == OP_QUICK_CONSTANT_LOAD
		|-> ##2 rsp.illegal == ($past(req.size, 2) != SZ_LONG))
		else $error("quick load size check wrong");
	AST_EOR_SRC: assert property (plain && req.op == OP_EXCLUSIVE_OR && req.size == SZ_WORD
		|-> ##2 rsp.illegal == !$past(req.src_is_dreg, 2))
		else $error("exclusive-or source check wrong");
	AST_LOOP_MODE: assert property (take && req.loop_en && req.eff_mode == AM_OTHER |-> ##2 rsp.illegal)
		else $error("loop mode accepted a bad address mode");
	// Main scenarios
	COV_REFUSED: cover property (rsp_valid && rsp.illegal);
	COV_LOOP: cover property (take && req.loop_en);
	COV_BACK_TO_BACK: cover property (rsp_valid && take);
endmodule : ict_timing_sva

/* ict_bus_model.sv */
module ict_bus_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus occupancy from the block
	input wire logic busy,
	// Bus cycles seen during the last run
	output logic [9:0] busy_cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	// Previous busy level, to find the start of a run
	logic prev_ff;
	// Count bus clocks of each run; restart on a new run only, so the figure survives the answer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
			busy_cycles <= 10'h000;
		end else begin
			prev_ff <= busy;
			if (busy && !prev_ff) begin
				busy_cycles <= 10'h001;
			end else if (busy) begin
				busy_cycles <= busy_cycles + 10'h001;
			end
		end
	end
endmodule : ict_bus_model

/* tb_top.sv */
module tb_top;
	import ict_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// Design inputs
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	ict_req_t req = '0;
	// Design outputs
	logic req_ready;
	logic rsp_valid;
	ict_rsp_t rsp;
	logic busy;
	logic [9:0] busy_cycles;
	// Score
	int mismatches = 0;
	int samples_checked = 0;
	always #2 core_clk = ~core_clk;
	ict_timing ict_timing_inst (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy));
	ict_bus_model ict_bus_model_inst (.core_clk(core_clk), .rst_n(rst_n), .busy(busy),
		.busy_cycles(busy_cycles));
	// Build a request; address cost always brings one read
	function automatic ict_req_t mk(ict_op_t o, ict_size_t s, ict_form_t f, logic sd, ict_mode_t m,
		logic [7:0] ec, logic le);
		mk = '{o, s, f, sd, m, '{ec, 4'h1, 4'h0}, le, LOOP_CONT};
	endfunction : mk
	// Build an answer
	function automatic ict_rsp_t ex(logic il, logic [9:0] c, logic [4:0] r, logic [4:0] w);
		ex = '{il, c, r, w};
	endfunction : ex
	// Compare an answer
	task automatic chk(input string nm, input ict_rsp_t e, input ict_rsp_t g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Compare a bus cycle count
	task automatic chk_n(input string nm, input logic [9:0] e, input logic [9:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s_run expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_n
	// One request, held until taken, then its answer judged
	task automatic run(input ict_req_t r, input ict_rsp_t e, input string nm);
		int n;
		n = 0;
		@(negedge core_clk);
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		req = r;
		req_valid = 1'b1;
		@(negedge core_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		// A missing answer counts as a mismatch of its own
		if (n >= 300) begin
			mismatches++;
			$display("MISMATCH %s_answer expected 1 seen 0", nm);
		end
		chk(nm, e, rsp);
		if (!e.illegal) chk_n(nm, e.clk, busy_cycles);
	endtask : run
	task automatic t_add();
		run(mk(OP_ADD, SZ_WORD, FORM_TO_AREG, 1'b0, AM_REG_IND, 8'h02, 1'b0), ex(1'b0, 10'h00A, 5'h02, 5'h00), "add_a");
		run(mk(OP_ADD, SZ_BYTE, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h02, 1'b0), ex(1'b0, 10'h006, 5'h02, 5'h00), "add_d");
		run(mk(OP_ADD, SZ_BYTE, FORM_TO_AREG, 1'b0, AM_REG_IND, 8'h02, 1'b0), ex(1'b1, '0, '0, '0), "add_ba");
		$display("t_add done");
	endtask : t_add
	task automatic t_muldiv();
		run(mk(OP_SIGNED_DIVISION, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h07E, 5'h02, 5'h00), "sdiv");
		run(mk(OP_UNSIGNED_DIVISION, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h070, 5'h02, 5'h00), "udiv");
		run(mk(OP_SIGNED_MULTIPLICATION, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h02E, 5'h02, 5'h00), "smul");
		run(mk(OP_UNSIGNED_MULTIPLICATION, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h02E, 5'h02, 5'h00), "umul");
		$display("t_muldiv done");
	endtask : t_muldiv
	task automatic t_eor();
		run(mk(OP_EXCLUSIVE_OR, SZ_BYTE, FORM_TO_DREG, 1'b1, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h004, 5'h01, 5'h00), "eor_b");
		run(mk(OP_EXCLUSIVE_OR, SZ_LONG, FORM_TO_DREG, 1'b1, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h006, 5'h01, 5'h00), "eor_l");
		run(mk(OP_EXCLUSIVE_OR, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b1, '0, '0, '0), "eor_src");
		$display("t_eor done");
	endtask : t_eor
	task automatic t_loop();
		ict_req_t r;
		r = mk(OP_ADD, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b1);
		run(r, ex(1'b0, 10'h010, 5'h01, 5'h00), "lp_ind");
		run(mk(OP_ADD, SZ_WORD, FORM_TO_DREG, 1'b0, AM_POSTINC, 8'h04, 1'b1), ex(1'b0, 10'h010, 5'h01, 5'h00), "lp_inc");
		run(mk(OP_ADD, SZ_WORD, FORM_TO_DREG, 1'b0, AM_PREDEC, 8'h04, 1'b1), ex(1'b0, 10'h012, 5'h01, 5'h00), "lp_dec");
		run(mk(OP_ADD, SZ_WORD, FORM_TO_DREG, 1'b0, AM_OTHER, 8'h04, 1'b1), ex(1'b1, '0, '0, '0), "lp_bad");
		// Loop ends on a true condition and on an expired count
		r.loop_state = LOOP_TRUE;
		run(r, ex(1'b0, 10'h016, 5'h03, 5'h00), "lp_true");
		r.loop_state = LOOP_EXPIRED;
		run(r, ex(1'b0, 10'h014, 5'h03, 5'h00), "lp_exp");
		$display("t_loop done");
	endtask : t_loop
	task automatic t_imm();
		run(mk(OP_ADD_IMMEDIATE, SZ_BYTE, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h008, 5'h02, 5'h00), "add_immediate_op_b");
		run(mk(OP_ADD_IMMEDIATE, SZ_LONG, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h00E, 5'h03, 5'h00), "add_immediate_op_l");
		run(mk(OP_COMPARE_IMMEDIATE, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h008, 5'h02, 5'h00), "compare_immediate_op_d");
		run(mk(OP_COMPARE_IMMEDIATE, SZ_WORD, FORM_TO_MEM, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h00C, 5'h03, 5'h00), "compare_immediate_op_m");
		$display("t_imm done");
	endtask : t_imm
	task automatic t_quick();
		run(mk(OP_QUICK_CONSTANT_LOAD, SZ_LONG, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b0, 10'h004, 5'h01, 5'h00), "ql_l");
		run(mk(OP_QUICK_CONSTANT_LOAD, SZ_WORD, FORM_TO_DREG, 1'b0, AM_REG_IND, 8'h04, 1'b0), ex(1'b1, '0, '0, '0), "ql_w");
		$display("t_quick done");
	endtask : t_quick
	// Counts, verdict, end of run
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		chk("reset", '0, rsp);
		t_add();
		t_muldiv();
		t_eor();
		t_loop();
		t_imm();
		t_quick();
		give_verdict();
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#60000;
		mismatches++;
		give_verdict();
	end
endmodule : tb_top
bind ict_timing ict_timing_sva ict_timing_sva_inst (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy));
